// [hw/fsm_consts.svh]
// Purpose: Constants for the motor fault and stall monitor
// Assumes: 40 MHz core clock
// Notes:   Times are in ns, cycle counts derive from them
`ifndef FSM_CONSTS_SVH
`define FSM_CONSTS_SVH

`define FSM_CLK_PERIOD_NS     25
// Filter, retry and open-load times are plain defaults, tune per product
`define FSM_OCP_FILTER_NS     2000
`define FSM_OCP_RETRY_NS      4000000
`define FSM_OL_DETECT_NS      200000000
// Least times round up to whole cycles
`define FSM_CYC_UP(t)         (((t) + `FSM_CLK_PERIOD_NS - 1) / `FSM_CLK_PERIOD_NS)
`define FSM_OCP_FILTER_CYC    `FSM_CYC_UP(`FSM_OCP_FILTER_NS)
`define FSM_OCP_RETRY_CYC     `FSM_CYC_UP(`FSM_OCP_RETRY_NS)
`define FSM_OL_DETECT_CYC     `FSM_CYC_UP(`FSM_OL_DETECT_NS)
`define FSM_AVG_DEPTH         4
`define FSM_LEARN_HALF_CYC    32
`define FSM_LEARN_MARGIN      8'h08
`define FSM_THRESHOLD_RESET   8'h00

`endif

// [hw/fsm_pkg.sv]
// Purpose: Types for the motor fault and stall monitor
// Assumes: Nothing
// Notes:   Learn states use Gray codes along idle, run, done
package fsm_pkg;
    typedef enum logic [1:0] {
        LEARN_IDLE = 2'h0,
        LEARN_RUN  = 2'h1,
        LEARN_DONE = 2'h3
    } fsm_learn_t;
endpackage

// [hw/fsm_monitor.sv]
// Purpose: Fault supervision and stall detection for a two-winding bridge
// Assumes: Comparator inputs synchronous to i_clock; i_srst is core reset
// Notes:   Fault line is open drain, driven low only through o_fault_line_n_oe
//
// Functional notes
// R01 - Supply undervoltage: outputs hi-Z, pump off until supply recovers
// R02 - Supply undervoltage above reset: set summary, supply flag, assert fault line
// R03 - Supply recovery releases line, clears summary; supply flag stays latched
// R04 - Core reset: flags read low, fault line released
// R05 - After reset, summary and line held until supply above rising threshold
// R06 - Pump undervoltage: outputs off, pump on, flags set, auto recovery
// R07 - Pump undervoltage flag stays until clear command or sleep pulse
// R08 - Current limit beyond filter time disables bridge, latches overcurrent flags
// R09 - Per-FET flags: short to supply sets low side, to ground high side
// R10 - Recovery mode 0: stays off and asserted until clear or power cycle
// R11 - Recovery mode 1: resumes after retry time once fault is gone
// R12 - Open load flagged only when enabled and coil low past detect time
// R13 - Open load latches summary flags plus per-winding flag
// R14 - Open load clears only when gone and cleared, or on sleep
// R15 - Stall detection runs only in valley ripple mode with enable set
// R16 - Eight-bit torque count from rising versus falling off-times
// R17 - Torque count below threshold latches stall and summary flags
// R18 - Stall drives fault line only when stall report enabled
// R19 - Stall flags and line released only by clear or sleep pulse; the code also releases the line when stall report is disabled
// R20 - Torque count averages last four half-cycles, held one half-cycle
// R21 - Stall detected within two electrical cycles
// R22 - Learn over sixteen electrical cycles loads threshold, sets done flag
// R23 - Fault line low while reported fault present, released otherwise
`timescale 1ns/1ps
`default_nettype none
`include "fsm_consts.svh"

module fsm_monitor #(
    parameter int unsigned RETRY_CYC = `FSM_OCP_RETRY_CYC,
    parameter int unsigned OL_CYC    = `FSM_OL_DETECT_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic       i_supply_uv,
    input  wire logic       i_pump_uv,
    input  wire logic [3:0] i_fet_limit_hs,
    input  wire logic [3:0] i_fet_limit_ls,
    input  wire logic [1:0] i_coil_low,
    input  wire logic       i_clear_faults_cmd,
    input  wire logic       i_sleep_pin_n,
    input  wire logic       i_overcurrent_recovery_mode,
    input  wire logic       i_open_load_enable,
    input  wire logic       i_ripple_decay_sel,
    input  wire logic       i_stall_detect_enable,
    input  wire logic       i_stall_report_enable,
    input  wire logic       i_stall_learn_enable,
    input  wire logic       i_threshold_wr,
    input  wire logic [7:0] i_threshold_wdata,
    input  wire logic       i_offtime_valid,
    input  wire logic       i_offtime_rising,
    input  wire logic [7:0] i_offtime,
    input  wire logic       i_half_cycle_end,
    output logic      [1:0] o_bridge_en,
    output logic            o_pump_en,
    output logic            o_fault_line_n_o,
    output logic            o_fault_line_n_oe,
    output logic            o_fault_flag,
    output logic            o_supply_undervoltage_flag,
    output logic            o_pump_undervoltage_flag,
    output logic            o_overcurrent_flag,
    output logic      [3:0] o_low_side_short_flag,
    output logic      [3:0] o_high_side_short_flag,
    output logic            o_open_load_flag,
    output logic            o_winding_a_open_flag,
    output logic            o_winding_b_open_flag,
    output logic            o_stall_flag,
    output logic            o_stall_summary_flag,
    output logic            o_stall_learn_done,
    output logic      [7:0] o_torque_load_count,
    output logic      [7:0] o_stall_threshold
);

    localparam int unsigned FILT_CYC = `FSM_OCP_FILTER_CYC;

    function automatic logic [7:0] sat8(input logic [12:0] v);
        sat8 = (v > 13'h00ff) ? 8'hff : v[7:0];
    endfunction

    // Fault state
    logic        pwrup_q, pwrup_d, suv_q, suv_d, puv_q, puv_d;
    logic [3:0]  ls_q, ls_d, hs_q, hs_d;
    logic [1:0]  ocoff_q, ocoff_d, ol_q, ol_d;
    logic [6:0]  filt_q [8], filt_d [8];
    logic [31:0] retry_q [2], retry_d [2], olcnt_q [2], olcnt_d [2];
    logic        stall_q, stall_d;
    // Torque state
    logic [11:0] rise_q, rise_d, fall_q, fall_d;
    logic [7:0]  hist_q [`FSM_AVG_DEPTH], hist_d [`FSM_AVG_DEPTH];
    logic [2:0]  fill_q, fill_d;
    logic        pub_q, pub_d;
    logic [7:0]  trq_q, trq_d, thr_q, thr_d;
    fsm_pkg::fsm_learn_t lst_q, lst_d;
    logic [5:0]  lcnt_q, lcnt_d;
    logic [12:0] lsum_q, lsum_d;
    logic        ldone_q, ldone_d;
    // Registered outputs
    logic [1:0]  bridge_q, bridge_d;
    logic        pump_q, pump_d, fline_q, fline_d, fault_q, fault_d;

    logic        clr;
    logic [7:0]  lim;
    logic [12:0] diff, asum;
    logic        stall_run;

    always_comb begin
        clr = i_clear_faults_cmd | ~i_sleep_pin_n;
        lim = {i_fet_limit_hs, i_fet_limit_ls};
        pwrup_d = pwrup_q & i_supply_uv;                           // [R05]
        // Set wins over clear on every latched flag
        // Power-up below the rising threshold reports only the summary flag
        suv_d = (i_supply_uv & ~pwrup_q) | (suv_q & ~clr);         // [R02] [R03] [R05]
        puv_d = i_pump_uv | (puv_q & ~clr);                        // [R06] [R07]
        ls_d = ls_q;
        hs_d = hs_q;
        ocoff_d = ocoff_q;
        for (int i = 0; i < 8; i++) begin
            filt_d[i] = lim[i] ? filt_q[i] + 7'h01 : 7'h00;
            // Saturate only while the limit persists, so a gone fault can be released
            if (lim[i] && filt_q[i] >= 7'(FILT_CYC)) begin
                filt_d[i] = filt_q[i];
            end
        end
        for (int i = 0; i < 4; i++) begin
            ls_d[i] = (filt_q[i] >= 7'(FILT_CYC)) | (ls_q[i] & ~clr);      // [R08] [R09]
            hs_d[i] = (filt_q[i + 4] >= 7'(FILT_CYC)) | (hs_q[i] & ~clr);  // [R09]
        end
        for (int b = 0; b < 2; b++) begin
            // Bit order within a nibble: winding A out1, A out2, B out1, B out2
            logic trip;
            logic live;
            trip = (filt_q[2*b] >= 7'(FILT_CYC)) | (filt_q[2*b+1] >= 7'(FILT_CYC))
                 | (filt_q[2*b+4] >= 7'(FILT_CYC)) | (filt_q[2*b+5] >= 7'(FILT_CYC));
            live = lim[2*b] | lim[2*b+1] | lim[2*b+4] | lim[2*b+5];
            retry_d[b] = 32'h0;
            ocoff_d[b] = trip | ocoff_q[b];                        // [R08]
            if (ocoff_q[b] & ~trip) begin
                if (i_overcurrent_recovery_mode) begin
                    retry_d[b] = (retry_q[b] < RETRY_CYC) ? retry_q[b] + 32'h1 : retry_q[b];
                    if (retry_q[b] >= RETRY_CYC && !live) begin
                        ocoff_d[b] = 1'b0;                         // [R11]
                    end
                end else if (clr) begin
                    ocoff_d[b] = 1'b0;                             // [R10]
                end
            end
            // Open load: enable-gated persistence, clear only once condition is gone
            olcnt_d[b] = (i_coil_low[b] & i_open_load_enable) ? olcnt_q[b] + 32'h1 : 32'h0;
            if (i_coil_low[b] && i_open_load_enable && olcnt_q[b] >= OL_CYC) begin
                olcnt_d[b] = olcnt_q[b];
            end
            ol_d[b] = (i_open_load_enable && olcnt_q[b] >= OL_CYC)                 // [R12] [R13]
                    | (ol_q[b] & ~(clr & ~i_coil_low[b]) & i_sleep_pin_n);          // [R14]
        end

        // Torque count: per half-cycle off-time difference, averaged over four
        rise_d = rise_q;
        fall_d = fall_q;
        if (i_offtime_valid) begin
            if (i_offtime_rising) begin
                rise_d = rise_q + {4'h0, i_offtime};
            end else begin
                fall_d = fall_q + {4'h0, i_offtime};
            end
        end
        diff = (rise_q > fall_q) ? {1'b0, rise_q - fall_q} : {1'b0, fall_q - rise_q};
        hist_d = hist_q;
        fill_d = fill_q;
        pub_d = 1'b0;
        if (i_half_cycle_end) begin
            rise_d = 12'h000;
            fall_d = 12'h000;
            for (int k = `FSM_AVG_DEPTH - 1; k > 0; k--) begin
                hist_d[k] = hist_q[k-1];
            end
            hist_d[0] = sat8(diff);                                // [R16]
            fill_d = (fill_q < 3'(`FSM_AVG_DEPTH)) ? fill_q + 3'h1 : fill_q;
            pub_d = 1'b1;
        end
        asum = 13'h0;
        for (int k = 0; k < `FSM_AVG_DEPTH; k++) begin
            asum = asum + {5'h00, hist_q[k]};
        end
        // Publish one cycle after the half-cycle closes, then hold
        trq_d = (pub_q && fill_q == 3'(`FSM_AVG_DEPTH)) ? asum[9:2] : trq_q;  // [R20]

        stall_run = i_ripple_decay_sel & i_stall_detect_enable & (lst_q != fsm_pkg::LEARN_RUN); // [R15]
        // Checked at every publish, so a stall shows within four half-cycles
        stall_d = (stall_run & pub_q & (fill_q == 3'(`FSM_AVG_DEPTH))
                   & (asum[9:2] < thr_q))                          // [R17] [R21]
                | (stall_q & ~clr);                                // [R19]

        // Learning: sum published counts over 32 half-cycles while stalled
        lst_d = lst_q;
        lcnt_d = lcnt_q;
        lsum_d = lsum_q;
        ldone_d = ldone_q;
        thr_d = i_threshold_wr ? i_threshold_wdata : thr_q;
        unique case (lst_q)
            fsm_pkg::LEARN_IDLE: begin
                if (i_stall_learn_enable) begin
                    lst_d = fsm_pkg::LEARN_RUN;
                    lcnt_d = 6'h00;
                    lsum_d = 13'h0000;
                    ldone_d = 1'b0;
                end
            end
            fsm_pkg::LEARN_RUN: begin
                if (!i_stall_learn_enable) begin
                    lst_d = fsm_pkg::LEARN_IDLE;
                end else if (pub_q && fill_q == 3'(`FSM_AVG_DEPTH)) begin
                    lcnt_d = lcnt_q + 6'h01;
                    lsum_d = lsum_q + {5'h00, asum[9:2]};
                    if (lcnt_q == 6'(`FSM_LEARN_HALF_CYC - 1)) begin
                        thr_d = sat8({5'h00, lsum_d[12:5]} + {5'h00, `FSM_LEARN_MARGIN}); // [R22]
                        ldone_d = 1'b1;                            // [R22]
                        lst_d = fsm_pkg::LEARN_DONE;
                    end
                end
            end
            fsm_pkg::LEARN_DONE: begin
                if (!i_stall_learn_enable) begin
                    lst_d = fsm_pkg::LEARN_IDLE;
                end
            end
            default: lst_d = fsm_pkg::LEARN_IDLE;
        endcase

        pump_d = ~i_supply_uv;                                     // [R01] [R06]
        bridge_d = (i_supply_uv | i_pump_uv) ? 2'b00 : ~ocoff_d;   // [R01] [R06] [R08]
        fault_d = i_supply_uv | pwrup_d | i_pump_uv | (|ocoff_d) | (|ol_d)
                | stall_d;                                         // [R02] [R03] [R05] [R06]
        fline_d = i_supply_uv | pwrup_d | i_pump_uv | (|ocoff_d) | (|ol_d)
                | (stall_d & i_stall_report_enable);               // [R18] [R23]
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            // Core reset: all flags low, line released, bridge and pump off
            pwrup_q <= 1'b1;                                       // [R04] [R05]
            suv_q <= 1'b0;
            puv_q <= 1'b0;
            ls_q <= 4'h0;
            hs_q <= 4'h0;
            ocoff_q <= 2'b00;
            ol_q <= 2'b00;
            stall_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                filt_q[i] <= 7'h00;
            end
            for (int b = 0; b < 2; b++) begin
                retry_q[b] <= 32'h0;
                olcnt_q[b] <= 32'h0;
            end
            rise_q <= 12'h000;
            fall_q <= 12'h000;
            for (int k = 0; k < `FSM_AVG_DEPTH; k++) begin
                hist_q[k] <= 8'h00;
            end
            fill_q <= 3'h0;
            pub_q <= 1'b0;
            trq_q <= 8'h00;
            thr_q <= `FSM_THRESHOLD_RESET;
            lst_q <= fsm_pkg::LEARN_IDLE;
            lcnt_q <= 6'h00;
            lsum_q <= 13'h0000;
            ldone_q <= 1'b0;
            bridge_q <= 2'b00;
            pump_q <= 1'b0;
            fline_q <= 1'b0;                                       // [R04]
            fault_q <= 1'b0;
        end else begin
            pwrup_q <= pwrup_d;
            suv_q <= suv_d;
            puv_q <= puv_d;
            ls_q <= ls_d;
            hs_q <= hs_d;
            ocoff_q <= ocoff_d;
            ol_q <= ol_d;
            stall_q <= stall_d;
            filt_q <= filt_d;
            retry_q <= retry_d;
            olcnt_q <= olcnt_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            hist_q <= hist_d;
            fill_q <= fill_d;
            pub_q <= pub_d;
            trq_q <= trq_d;
            thr_q <= thr_d;
            lst_q <= lst_d;
            lcnt_q <= lcnt_d;
            lsum_q <= lsum_d;
            ldone_q <= ldone_d;
            bridge_q <= bridge_d;
            pump_q <= pump_d;
            fline_q <= fline_d;
            fault_q <= fault_d;
        end
    end

    always_comb begin
        o_bridge_en = bridge_q;
        o_pump_en = pump_q;
        o_fault_line_n_o = 1'b0;
        o_fault_line_n_oe = fline_q;
        o_fault_flag = fault_q;
        o_supply_undervoltage_flag = suv_q;
        o_pump_undervoltage_flag = puv_q;
        o_overcurrent_flag = |{ls_q, hs_q};
        o_low_side_short_flag = ls_q;
        o_high_side_short_flag = hs_q;
        o_open_load_flag = |ol_q;
        o_winding_a_open_flag = ol_q[0];
        o_winding_b_open_flag = ol_q[1];
        o_stall_flag = stall_q;
        o_stall_summary_flag = stall_q;
        o_stall_learn_done = ldone_q;
        o_torque_load_count = trq_q;
        o_stall_threshold = thr_q;
    end

endmodule // fsm_monitor
`default_nettype wire

// [verif/fsm_monitor_props.sv]
// Purpose: Port-level checker for fsm_monitor
// Assumes: Bound into every fsm_monitor instance
// Notes:   One or two cycles of output lag are tolerated
`timescale 1ns/1ps
`default_nettype none
module fsm_monitor_chk #(
    parameter int unsigned OL_CYC = 16
) (
    input wire logic       i_clock, i_srst, i_supply_uv, i_pump_uv, i_clear_faults_cmd,
    input wire logic       i_sleep_pin_n, i_overcurrent_recovery_mode, i_open_load_enable,
    input wire logic       i_stall_report_enable, i_stall_learn_enable, i_half_cycle_end,
    input wire logic [3:0] i_fet_limit_hs, i_fet_limit_ls,
    input wire logic [1:0] i_coil_low, o_bridge_en,
    input wire logic       o_pump_en, o_fault_line_n_oe, o_fault_flag, o_overcurrent_flag,
    input wire logic       o_supply_undervoltage_flag, o_pump_undervoltage_flag,
    input wire logic       o_open_load_flag, o_winding_a_open_flag, o_winding_b_open_flag,
    input wire logic       o_stall_flag, o_stall_summary_flag, o_stall_learn_done,
    input wire logic [3:0] o_low_side_short_flag, o_high_side_short_flag,
    input wire logic [7:0] o_torque_load_count
);
    logic [7:0]  lim_q, lim_d;
    int unsigned ol_q, ol_d;
    logic [14:0] lat;
    logic        quiet;
    assign lat = {o_supply_undervoltage_flag, o_pump_undervoltage_flag, o_open_load_flag,
                  o_low_side_short_flag, o_high_side_short_flag, o_stall_flag, 3'h0};
    assign quiet = i_sleep_pin_n && !i_clear_faults_cmd;
    // Run lengths of current limit (saturating at 8'hff) and of enabled low coil current (not saturating)
    always_comb begin
        lim_d = (|{i_fet_limit_hs, i_fet_limit_ls}) ? lim_q + {7'h00, lim_q != 8'hff} : 8'h00;
        ol_d  = (i_open_load_enable && |i_coil_low) ? ol_q + 1 : 0;
    end
    always_ff @(posedge i_clock) begin
        lim_q <= i_srst ? 8'h00 : lim_d;
        ol_q  <= i_srst ? 0 : ol_d;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    property p_uv_off;
        i_supply_uv [*3] |-> o_bridge_en == 2'h0 && !o_pump_en && o_fault_line_n_oe && o_fault_flag;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("bridge or pump live in low supply");
    property p_uv_flag;
        !i_supply_uv ##1 i_supply_uv [*3] |-> o_supply_undervoltage_flag;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("supply flag not set");
    property p_idle;
        (!i_supply_uv && !i_pump_uv && !o_overcurrent_flag && !o_open_load_flag
         && !o_stall_flag) [*3] |-> !o_fault_flag && !o_fault_line_n_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("fault reported with no cause");
    property p_pump;
        (i_pump_uv && !i_supply_uv) [*3] |-> o_bridge_en == 2'h0 && o_pump_en
            && o_pump_undervoltage_flag && o_fault_line_n_oe;
    endproperty
    a_pump: assert property (p_pump) else $error("pump undervoltage response wrong");
    property p_latch;
        quiet && $past(quiet) |=> (lat & $past(lat)) == $past(lat);
    endproperty
    a_latch: assert property (p_latch) else $error("latched flag dropped");
    property p_ocp_trip;
        $rose(o_overcurrent_flag) |-> lim_q >= 8'h50;
    endproperty
    a_ocp_trip: assert property (p_ocp_trip) else $error("overcurrent before filter");
    property p_ocp_hold;
        !i_overcurrent_recovery_mode && quiet && $past(quiet)
            && |{o_low_side_short_flag[1:0], o_high_side_short_flag[1:0]}
            |-> !o_bridge_en[0] && o_fault_line_n_oe;
    endproperty
    a_ocp_hold: assert property (p_ocp_hold) else $error("bridge A live after short");
    property p_ol;
        $rose(o_open_load_flag) |-> ol_q >= OL_CYC && $past(i_open_load_enable);
    endproperty
    a_ol: assert property (p_ol) else $error("open load flagged early");
    property p_ol_wind;
        o_winding_a_open_flag || o_winding_b_open_flag
            |-> o_open_load_flag && o_fault_flag && o_fault_line_n_oe;
    endproperty
    a_ol_wind: assert property (p_ol_wind) else $error("winding flag alone");
    property p_stall_rep;
        o_stall_flag && $past(o_stall_flag) && i_stall_report_enable
            && $past(i_stall_report_enable) |-> o_fault_line_n_oe && o_stall_summary_flag;
    endproperty
    a_stall_rep: assert property (p_stall_rep) else $error("stall not on fault line");
    property p_trq_hold;
        $changed(o_torque_load_count) |-> $past(i_half_cycle_end)
            || $past(i_half_cycle_end, 2) || $past(i_half_cycle_end, 3);
    endproperty
    a_trq_hold: assert property (p_trq_hold) else $error("count moved mid half-cycle");
    c_stall: cover property ($rose(o_stall_flag));
    c_ol: cover property ($rose(o_open_load_flag));
    c_learn: cover property ($rose(o_stall_learn_done) && i_stall_learn_enable);
endmodule // fsm_monitor_chk
bind fsm_monitor fsm_monitor_chk #(.OL_CYC(OL_CYC)) u_fsm_monitor_chk (.*);
`default_nettype wire

// [verif/fsm_host.sv]
// Purpose: Host controller model facing the monitor
// Assumes: Requests come from the bench between clock edges
// Notes:   Fault line has an external pull-up
`timescale 1ns/1ps
`default_nettype none
module fsm_host (
    input  wire logic i_clock, i_clear_req, i_sleep_req, i_fault_line_n_o, i_fault_line_n_oe,
    output var logic  o_clear_faults_cmd, o_sleep_pin_n,
    output wire logic o_fault_line_n
);
    // Released line reads the pull-up level, never the last driven value
    assign o_fault_line_n = i_fault_line_n_oe ? i_fault_line_n_o : 1'h1;
    always @(posedge i_clock) begin
        o_clear_faults_cmd <= i_clear_req;
        o_sleep_pin_n <= !i_sleep_req;
    end
endmodule // fsm_host
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for fsm_monitor
// Assumes: 40 MHz clock, inputs driven on falling edges
// Notes:   Short retry and open-load counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int unsigned OLC = 16;
    logic clk, srst, suv, puv, mode, ol_en, rip, stl_en, rep, lrn, thr_wr, ov, orise, hce;
    logic clr_req, slp_req, clr, slp_n, fn_o, fn_oe, fn, pump, flt, fuv, fpv, fov, fol;
    logic fwa, fwb, fst, fss, done;
    logic [3:0] lhs, lls, ls, hs;
    logic [1:0] coil, br;
    logic [7:0] thr_d, ot, trq, thr;
    logic [23:0] got;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    logic [23:0] ce[2] = '{24'ha90020, 24'h690004};
    int fail_count = 0, checked = 0, tick = 0;
    event chk;
    fsm_monitor #(.RETRY_CYC(20), .OL_CYC(OLC)) u_fsm_monitor (
        .i_clock(clk), .i_srst(srst), .i_supply_uv(suv), .i_pump_uv(puv),
        .i_fet_limit_hs(lhs), .i_fet_limit_ls(lls), .i_coil_low(coil),
        .i_clear_faults_cmd(clr), .i_sleep_pin_n(slp_n), .i_overcurrent_recovery_mode(mode),
        .i_open_load_enable(ol_en), .i_ripple_decay_sel(rip), .i_stall_detect_enable(stl_en),
        .i_stall_report_enable(rep), .i_stall_learn_enable(lrn), .i_threshold_wr(thr_wr),
        .i_threshold_wdata(thr_d), .i_offtime_valid(ov), .i_offtime_rising(orise),
        .i_offtime(ot), .i_half_cycle_end(hce), .o_bridge_en(br), .o_pump_en(pump),
        .o_fault_line_n_o(fn_o), .o_fault_line_n_oe(fn_oe), .o_fault_flag(flt),
        .o_supply_undervoltage_flag(fuv), .o_pump_undervoltage_flag(fpv),
        .o_overcurrent_flag(fov), .o_low_side_short_flag(ls), .o_high_side_short_flag(hs),
        .o_open_load_flag(fol), .o_winding_a_open_flag(fwa), .o_winding_b_open_flag(fwb),
        .o_stall_flag(fst), .o_stall_summary_flag(fss), .o_stall_learn_done(done),
        .o_torque_load_count(trq), .o_stall_threshold(thr));
    fsm_host u_fsm_host (.i_clock(clk), .i_clear_req(clr_req), .i_sleep_req(slp_req),
        .i_fault_line_n_o(fn_o), .i_fault_line_n_oe(fn_oe), .o_clear_faults_cmd(clr),
        .o_sleep_pin_n(slp_n), .o_fault_line_n(fn));
    assign got = {br, pump, fn, flt, fuv, fpv, fov, fol, fwa, fwb, fst, fss, done, 2'h0, ls, hs};
    task automatic final_report;
        $display("compares %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Mode 1 also compares torque count, mode 2 the stall threshold
    task automatic ex(input logic [23:0] st, input logic [1:0] md = 2'h0, input logic [7:0] v = 8'h00);
        exp_q.push_back({md, v, st});
        -> chk;
        @(negedge clk);
    endtask
    task automatic clear(input logic sl);
        if (sl) slp_req = 1'h1;
        else clr_req = 1'h1;
        @(negedge clk);
        {clr_req, slp_req} = 2'h0;
        wt(4);
    endtask
    task automatic hc(input logic [7:0] r, input logic [7:0] f, input int n);
        repeat (n) begin
            ov = 1'h1; orise = 1'h1; ot = r; @(negedge clk);
            orise = 1'h0; ot = f; @(negedge clk);
            ov = 1'h0; hce = 1'h1; @(negedge clk);
            hce = 1'h0; wt(4);
        end
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    always @(chk) begin
        e = exp_q.pop_front();
        checked++;
        if (got !== e[23:0] || (e[33:32] == 2'h1 && trq !== e[31:24])
            || (e[33:32] == 2'h2 && thr !== e[31:24])) begin
            fail_count++;
            $display("[FAIL] %0t status %h want %h count %h thr %h", $time, got, e[23:0], trq, thr);
        end
    end
    always @(posedge clk) begin
        tick++;
        if (tick == 20000) begin
            fail_count++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {srst, suv} = 2'h3;
        {puv, mode, ol_en, rip, stl_en, rep, lrn, thr_wr, ov, orise, hce} = 11'h000;
        {clr_req, slp_req, lls, lhs, coil, thr_d, ot} = 28'h0000000;
        void'($urandom(92115));
        wt(14);
        ex(24'h100000);
        wt(1);
        srst = 1'h0;
        wt(3);
        ex(24'h080000);
        suv = 1'h0; wt(3);
        ex(24'hf00000);
        tend("power-up");
        suv = 1'h1; wt(3);
        ex(24'h0c0000);
        suv = 1'h0; wt(3);
        ex(24'hf40000);
        clear(1'h0);
        ex(24'hf00000);
        puv = 1'h1; wt(3);
        ex(24'h2a0000);
        puv = 1'h0; wt(3);
        ex(24'hf20000);
        clear(1'h1);
        ex(24'hf00000);
        tend("undervoltage");
        foreach (ce[i]) begin
            {lls, lhs} = ce[i][7:0]; wt($urandom_range(70, 1));
            {lls, lhs} = 8'h00; wt(4);
            ex(24'hf00000);
            {lls, lhs} = ce[i][7:0]; wt(90);
            ex(ce[i]);
            {lls, lhs} = 8'h00; wt(10);
            ex(ce[i]);
            clear(1'h0);
            ex(24'hf00000);
        end
        mode = 1'h1; lls = 4'h1; wt(90);
        ex(24'ha90010);
        lls = 4'h0; wt(5);
        ex(24'ha90010);
        wt(30);
        ex(24'hf10010);
        clear(1'h0);
        mode = 1'h0;
        ex(24'hf00000);
        tend("overcurrent");
        coil = 2'h2; wt(OLC + 10);
        ex(24'hf00000);
        ol_en = 1'h1; wt(OLC + 6);
        ex(24'he8a000);
        clear(1'h0);
        ex(24'he8a000);
        coil = 2'h0; wt(2);
        ex(24'he8a000);
        clear(1'h0);
        ex(24'hf00000);
        ol_en = 1'h0;
        tend("open load");
        thr_d = 8'h20; thr_wr = 1'h1; @(negedge clk);
        thr_wr = 1'h0;
        ex(24'hf00000, 2'h2, 8'h20);
        stl_en = 1'h1; hc(8'h40, 8'h30, 4);
        ex(24'hf00000);
        // Refill the history with detection off so no partial average trips
        stl_en = 1'h0; rip = 1'h1; hc(8'h40, 8'h10, 4);
        ex(24'hf00000, 2'h1, 8'h30);
        stl_en = 1'h1; hc(8'h40, 8'h40, 1);
        ex(24'hf00000, 2'h1, 8'h24);
        hc(8'h40, 8'h40, 1);
        ex(24'hf81800, 2'h1, 8'h18);
        rep = 1'h1; wt(2);
        ex(24'he81800);
        stl_en = 1'h0;
        clear(1'h0);
        ex(24'hf00000, 2'h1, 8'h18);
        rep = 1'h0; hc(8'h40, 8'h18, 4);
        lrn = 1'h1; hc(8'h40, 8'h18, 32);
        ex(24'hf00400, 2'h2, 8'h30);
        tend("stall");
        final_report();
    end
endmodule // tb
`default_nettype wire
